/* File: src/cad_cfg.svh */
`ifndef CAD_CFG_SVH
`define CAD_CFG_SVH
`define CAD_B1_CMP_AUTO   8'h16
`define CAD_B1_CMP_IDX    8'h17
`define CAD_B1_CMP_OFS8   8'h06
`define CAD_B1_CMP_OFS24  8'h0a
`define CAD_B1_AND_ACC    8'hac
`define CAD_B1_AND_REG    8'h7c
`define CAD_B1_AND_SLO    8'h6c
`define CAD_B1_AND_SHI    8'h3c
`define CAD_B1_AND_SFR    8'h01
`define CAD_B2_AND_SUB    8'h6c
`define CAD_CMP_LOW_NIB   4'hf
`define CAD_AND_REG_NIB   4'h3
`endif

/* File: src/cad_pkg.sv */
`default_nettype none
package cad_pkg;
	typedef enum logic [3:0] {
		CAD_BASE_NONE  = 4'h0,
		CAD_BASE_PTR_A = 4'h1,
		CAD_BASE_PTR_B = 4'h2,
		CAD_BASE_PTR_C = 4'h3,
		CAD_BASE_PTR_D = 4'h4,
		CAD_BASE_SP    = 4'h5,
		CAD_BASE_ACC   = 4'h6,
		CAD_BASE_PAIRX = 4'h7,
		CAD_BASE_PAIRY = 4'h8,
		CAD_BASE_IDX1  = 4'h9
	} cad_base_t;
	typedef enum logic [3:0] {
		CAD_IDX_NONE  = 4'h0,
		CAD_IDX_ACC   = 4'h1,
		CAD_IDX_ONE   = 4'h2,
		CAD_IDX_TWO   = 4'h3,
		CAD_IDX_PAIRX = 4'h4,
		CAD_IDX_PAIRY = 4'h5
	} cad_idx_t;
	typedef enum logic [3:0] {
		CAD_AM_NONE   = 4'h0,
		CAD_AM_IND    = 4'h1,
		CAD_AM_POSTIN = 4'h2,
		CAD_AM_POSTDE = 4'h3,
		CAD_AM_OFS8   = 4'h4,
		CAD_AM_OFS24  = 4'h5,
		CAD_AM_REGIDX = 4'h6,
		CAD_AM_IMM    = 4'h7,
		CAD_AM_REG    = 4'h8,
		CAD_AM_SLO    = 4'h9,
		CAD_AM_SHI    = 4'ha,
		CAD_AM_SFR    = 4'hb
	} cad_am_t;
	typedef enum logic [1:0] {
		CAD_OP_NONE = 2'h0,
		CAD_OP_CMP  = 2'h1,
		CAD_OP_AND  = 2'h2
	} cad_op_t;
	typedef struct packed {
		logic [7:0] data;
	} cad_byte_t;
	typedef struct packed {
		cad_op_t    op;
		cad_am_t    mode;
		cad_base_t  base;
		cad_idx_t   index;
		logic       mem_first;
		logic       write_back;
		logic [3:0] dest_reg;
		logic [23:0] offset;
		logic [7:0] imm;
		logic [2:0] length;
	} cad_dec_t;
	typedef enum logic [2:0] {
		CAD_ST_B1  = 3'h0,
		CAD_ST_B2  = 3'h1,
		CAD_ST_B3  = 3'h2,
		CAD_ST_B4  = 3'h3,
		CAD_ST_B5  = 3'h4
	} cad_state_t;
endpackage
`default_nettype wire

/* File: src/cad_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cad_cfg.svh"
// Contract
// - Accumulator-first register-indexed compare, high nibbles 3-7.
// - Compare base plus byte offset, third byte.
// - Compare 24-bit offset plus register, five bytes.
// - Memory-first base-plus-register compare, nibbles 8-f.
// - AND accumulator with immediate, two bytes.
// - AND register with immediate, nibble selects.
// - AND lower short-direct location with immediate.
// - AND upper short-direct location with immediate.
// - AND special-function location with immediate.
module cad_decoder (
	input  wire logic             core_clk_in,
	input  wire logic             resetn_in,
	input  wire logic             byte_valid_in,
	input  wire cad_pkg::cad_byte_t byte_in,
	output logic                  byte_ready_out,
	output logic                  dec_valid_out,
	output logic                  dec_illegal_out,
	output cad_pkg::cad_dec_t     dec_out
);
	cad_pkg::cad_state_t st_reg, st_next;
	cad_pkg::cad_dec_t   cur_reg, cur_next;
	logic [7:0]          b1_reg, b1_next;
	cad_pkg::cad_dec_t   out_reg, out_next;
	logic                val_reg, val_next;
	logic                ill_reg, ill_next;

	function automatic cad_pkg::cad_base_t ptr_sel(input logic [1:0] s);
		case (s)
			2'h0: ptr_sel = cad_pkg::CAD_BASE_PTR_B;
			2'h1: ptr_sel = cad_pkg::CAD_BASE_PTR_A;
			2'h2: ptr_sel = cad_pkg::CAD_BASE_PTR_C;
			default: ptr_sel = cad_pkg::CAD_BASE_PTR_D;
		endcase
	endfunction

	assign byte_ready_out  = 1'b1;
	assign dec_valid_out   = val_reg;
	assign dec_illegal_out = ill_reg;
	assign dec_out         = out_reg;

	always_comb begin
		logic [7:0] b;
		logic       done;
		logic       bad;
		b        = byte_in.data;
		done     = 1'b0;
		bad      = 1'b0;
		st_next  = st_reg;
		cur_next = cur_reg;
		b1_next  = b1_reg;
		if (byte_valid_in) begin
			case (st_reg)
				cad_pkg::CAD_ST_B1: begin
					b1_next  = b;
					cur_next = '0;
					cur_next.length = 3'h1;
					st_next  = cad_pkg::CAD_ST_B2;
					case (b)
						`CAD_B1_CMP_AUTO, `CAD_B1_CMP_IDX, `CAD_B1_CMP_OFS8, `CAD_B1_CMP_OFS24:
							cur_next.op = cad_pkg::CAD_OP_CMP;
						`CAD_B1_AND_ACC, `CAD_B1_AND_REG, `CAD_B1_AND_SLO, `CAD_B1_AND_SHI, `CAD_B1_AND_SFR: begin
							cur_next.op         = cad_pkg::CAD_OP_AND;
							cur_next.write_back = 1'b1;
						end
						default: begin
							bad     = 1'b1;
							st_next = cad_pkg::CAD_ST_B1;
						end
					endcase
				end
				cad_pkg::CAD_ST_B2: begin
					cur_next.length = 3'h2;
					st_next = cad_pkg::CAD_ST_B3;
					if (cur_reg.op == cad_pkg::CAD_OP_CMP) begin
						cur_next.mem_first = b[7];
						if (b[3:0] != `CAD_CMP_LOW_NIB) begin
							bad = 1'b1;
						end else begin
							case (b1_reg)
								`CAD_B1_CMP_AUTO: begin
									// Accumulator-first forms of this group lie outside this block.
									bad = !b[7];
									cur_next.base = ptr_sel(b[5:4]);
									case (b[6:4])
										3'h0, 3'h1: cur_next.mode = cad_pkg::CAD_AM_POSTIN;
										3'h2, 3'h3: begin
											cur_next.base = ptr_sel({1'b0, b[4]});
											cur_next.mode = cad_pkg::CAD_AM_POSTDE;
										end
										default: cur_next.mode = cad_pkg::CAD_AM_IND;
									endcase
									// Auto-step forms reach only the b and a pointers; plain forms reach all four.
									done = 1'b1;
								end
								`CAD_B1_CMP_IDX: begin
									cur_next.mode = cad_pkg::CAD_AM_REGIDX;
									bad = !b[7] && (b[6:4] < 3'h3);
									case (b[6:4])
										3'h0: begin cur_next.base = cad_pkg::CAD_BASE_PTR_B; cur_next.index = cad_pkg::CAD_IDX_ACC; end
										3'h1: begin cur_next.base = cad_pkg::CAD_BASE_PTR_A; cur_next.index = cad_pkg::CAD_IDX_ACC; end
										3'h2: begin cur_next.base = cad_pkg::CAD_BASE_PTR_B; cur_next.index = cad_pkg::CAD_IDX_ONE; end
										3'h3: begin cur_next.base = cad_pkg::CAD_BASE_PTR_A; cur_next.index = cad_pkg::CAD_IDX_ONE; end
										3'h4: begin cur_next.base = cad_pkg::CAD_BASE_PTR_C; cur_next.index = cad_pkg::CAD_IDX_PAIRX; end
										3'h5: begin cur_next.base = cad_pkg::CAD_BASE_PTR_C; cur_next.index = cad_pkg::CAD_IDX_PAIRY; end
										3'h6: begin cur_next.base = cad_pkg::CAD_BASE_PTR_B; cur_next.index = cad_pkg::CAD_IDX_TWO; end
										default: begin cur_next.base = cad_pkg::CAD_BASE_PTR_A; cur_next.index = cad_pkg::CAD_IDX_TWO; end
									endcase
									done = 1'b1;
								end
								`CAD_B1_CMP_OFS8: begin
									cur_next.mode = cad_pkg::CAD_AM_OFS8;
									bad = (b[6:4] > 3'h4);
									case (b[6:4])
										3'h0: cur_next.base = cad_pkg::CAD_BASE_PTR_B;
										3'h1: cur_next.base = cad_pkg::CAD_BASE_SP;
										3'h2: cur_next.base = cad_pkg::CAD_BASE_PTR_A;
										3'h3: cur_next.base = cad_pkg::CAD_BASE_PTR_D;
										default: cur_next.base = cad_pkg::CAD_BASE_PTR_C;
									endcase
								end
								default: begin
									cur_next.mode = cad_pkg::CAD_AM_OFS24;
									bad = (b[6:4] > 3'h3);
									case (b[6:4])
										3'h0: cur_next.base = cad_pkg::CAD_BASE_PAIRX;
										3'h1: cur_next.base = cad_pkg::CAD_BASE_ACC;
										3'h2: cur_next.base = cad_pkg::CAD_BASE_PAIRY;
										default: cur_next.base = cad_pkg::CAD_BASE_IDX1;
									endcase
								end
							endcase
						end
					end else begin
						case (b1_reg)
							`CAD_B1_AND_ACC: begin
								cur_next.mode = cad_pkg::CAD_AM_IMM;
								cur_next.imm  = b;
								done = 1'b1;
							end
							`CAD_B1_AND_REG: begin
								cur_next.mode     = cad_pkg::CAD_AM_REG;
								cur_next.dest_reg = b[7:4];
								bad = (b[3:0] != `CAD_AND_REG_NIB);
							end
							`CAD_B1_AND_SLO: begin
								cur_next.mode   = cad_pkg::CAD_AM_SLO;
								cur_next.offset = {16'h0000, b};
							end
							default: begin
								cur_next.mode = (b1_reg == `CAD_B1_AND_SHI) ? cad_pkg::CAD_AM_SHI
									: cad_pkg::CAD_AM_SFR;
								bad = (b != `CAD_B2_AND_SUB);
							end
						endcase
					end
				end
				cad_pkg::CAD_ST_B3: begin
					cur_next.length = 3'h3;
					st_next = cad_pkg::CAD_ST_B4;
					case (cur_reg.mode)
						cad_pkg::CAD_AM_OFS8: begin
							cur_next.offset = {16'h0000, b};
							done = 1'b1;
						end
						cad_pkg::CAD_AM_REG, cad_pkg::CAD_AM_SLO: begin
							cur_next.imm = b;
							done = 1'b1;
						end
						default: cur_next.offset = {16'h0000, b};
					endcase
				end
				cad_pkg::CAD_ST_B4: begin
					cur_next.length = 3'h4;
					st_next = cad_pkg::CAD_ST_B5;
					if (cur_reg.mode == cad_pkg::CAD_AM_OFS24) begin
						cur_next.offset[15:8] = b;
					end else begin
						cur_next.imm = b;
						done = 1'b1;
					end
				end
				cad_pkg::CAD_ST_B5: begin
					cur_next.length = 3'h5;
					cur_next.offset[23:16] = b;
					done = 1'b1;
				end
				default: st_next = cad_pkg::CAD_ST_B1;
			endcase
			if (done || bad)
				st_next = cad_pkg::CAD_ST_B1;
		end
		val_next = byte_valid_in && done && !bad;
		ill_next = byte_valid_in && bad;
		out_next = val_next ? cur_next : out_reg;
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_reg  <= cad_pkg::CAD_ST_B1;
			cur_reg <= '0;
			b1_reg  <= 8'h00;
			out_reg <= '0;
			val_reg <= 1'b0;
			ill_reg <= 1'b0;
		end else begin
			st_reg  <= st_next;
			cur_reg <= cur_next;
			b1_reg  <= b1_next;
			out_reg <= out_next;
			val_reg <= val_next;
			ill_reg <= ill_next;
		end
	end
endmodule
`default_nettype wire

/* File: bench/cad_decoder_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module cad_decoder_monitor (
	input wire logic               core_clk_in,
	input wire logic               resetn_in,
	input wire logic               byte_valid_in,
	input wire cad_pkg::cad_byte_t byte_in,
	input wire logic               byte_ready_out,
	input wire logic               dec_valid_out,
	input wire logic               dec_illegal_out,
	input wire cad_pkg::cad_dec_t  dec_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	// Every instruction here is at least two bytes, so two decodes cannot land on adjacent cycles.
	property p_pulse; dec_valid_out |=> !dec_valid_out; endproperty
	a_pulse: assert property (p_pulse) else $error("decode pulse longer than one cycle");
	property p_hold; !dec_valid_out && $past(resetn_in) |-> $stable(dec_out); endproperty
	a_hold: assert property (p_hold) else $error("decode changed without a pulse");
	property p_cmp_wb; dec_valid_out && dec_out.op == cad_pkg::CAD_OP_CMP |-> !dec_out.write_back; endproperty
	a_cmp_wb: assert property (p_cmp_wb) else $error("compare asks for write back");
	property p_and_imm;
		dec_valid_out && dec_out.op == cad_pkg::CAD_OP_AND |-> dec_out.write_back && dec_out.imm == $past(byte_in.data);
	endproperty
	a_and_imm: assert property (p_and_imm) else $error("logic op immediate or write back wrong");
	property p_imm_len;
		dec_valid_out && dec_out.mode == cad_pkg::CAD_AM_IMM |-> dec_out.op == cad_pkg::CAD_OP_AND && dec_out.length == 3'h2;
	endproperty
	a_imm_len: assert property (p_imm_len) else $error("accumulator immediate length wrong");
	property p_ofs8;
		dec_valid_out && dec_out.mode == cad_pkg::CAD_AM_OFS8 |-> dec_out.length == 3'h3 && dec_out.offset[7:0] == $past(byte_in.data);
	endproperty
	a_ofs8: assert property (p_ofs8) else $error("byte offset form wrong");
	property p_ofs24;
		dec_valid_out && dec_out.mode == cad_pkg::CAD_AM_OFS24 |-> dec_out.length == 3'h5 && dec_out.offset[23:16] == $past(byte_in.data);
	endproperty
	a_ofs24: assert property (p_ofs24) else $error("wide offset form wrong");
	property p_two;
		dec_valid_out && dec_out.mode inside {cad_pkg::CAD_AM_IND, cad_pkg::CAD_AM_POSTIN, cad_pkg::CAD_AM_POSTDE,
			cad_pkg::CAD_AM_REGIDX} |-> dec_out.length == 3'h2 && dec_out.op == cad_pkg::CAD_OP_CMP;
	endproperty
	a_two: assert property (p_two) else $error("pointer compare length wrong");
	property p_four;
		dec_valid_out && dec_out.mode inside {cad_pkg::CAD_AM_SHI, cad_pkg::CAD_AM_SFR} |-> dec_out.length == 3'h4;
	endproperty
	a_four: assert property (p_four) else $error("prefixed logic op length wrong");
endmodule
bind cad_decoder cad_decoder_monitor i_cad_decoder_monitor (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
	.byte_valid_in(byte_valid_in), .byte_in(byte_in), .byte_ready_out(byte_ready_out),
	.dec_valid_out(dec_valid_out), .dec_illegal_out(dec_illegal_out), .dec_out(dec_out));
`default_nettype wire

/* File: bench/cad_fetch_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cad_fetch_model (
	input  wire logic         core_clk_in,
	output logic              byte_valid_out,
	output cad_pkg::cad_byte_t byte_out
);
	initial begin
		byte_valid_out = 1'b0;
		byte_out = 8'h00;
	end
	// Each idle cycle inverts the byte shown before it, so a stale byte never passes for a fresh one.
	task automatic send(input logic [7:0] b[$], input int gap);
		foreach (b[i]) begin
			repeat ((i > 0) ? gap : 0) begin
				@(negedge core_clk_in);
				byte_valid_out = 1'b0;
				byte_out.data = ~byte_out.data;
			end
			@(negedge core_clk_in);
			byte_valid_out = 1'b1;
			byte_out.data = b[i];
		end
		@(negedge core_clk_in);
		byte_valid_out = 1'b0;
		byte_out.data = ~byte_out.data;
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_cad_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_cad_decoder;
	logic               core_clk_in = 1'b0;
	logic               resetn_in = 1'b0;
	logic               byte_valid_in;
	cad_pkg::cad_byte_t byte_in;
	logic               byte_ready_out;
	logic               dec_valid_out;
	logic               dec_illegal_out;
	cad_pkg::cad_dec_t  dec_out;
	int                 failures = 0;
	int                 samples_checked = 0;
	always #50 core_clk_in = ~core_clk_in;
	cad_decoder i_cad_decoder (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .byte_valid_in(byte_valid_in),
		.byte_in(byte_in), .byte_ready_out(byte_ready_out), .dec_valid_out(dec_valid_out),
		.dec_illegal_out(dec_illegal_out), .dec_out(dec_out));
	cad_fetch_model i_cad_fetch_model (.core_clk_in(core_clk_in), .byte_valid_out(byte_valid_in), .byte_out(byte_in));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic cad_pkg::cad_dec_t mk(input logic [1:0] op, input logic [3:0] am, input logic [3:0] bs,
		input logic [3:0] ix, input logic mf, input logic [23:0] ofs, input logic [7:0] imm, input logic [2:0] len,
		input logic [3:0] dr);
		mk = {op, am, bs, ix, mf, op == 2'h2, dr, ofs, imm, len};
	endfunction
	// An all-zero expectation stands for an encoding that must be flagged as foreign.
	task automatic run(input logic [7:0] b[$], input int gap, input cad_pkg::cad_dec_t e);
		i_cad_fetch_model.send(b, gap);
		chk("ready", 1'b1, byte_ready_out);
		chk("illegal", e.op === cad_pkg::CAD_OP_NONE, dec_illegal_out);
		chk("valid", e.op !== cad_pkg::CAD_OP_NONE, dec_valid_out);
		if (e.op === cad_pkg::CAD_OP_NONE) return;
		chk("op mode length", {e.op, e.mode, e.length}, {dec_out.op, dec_out.mode, dec_out.length});
		chk("write_back", e.write_back, dec_out.write_back);
		if (e.op === cad_pkg::CAD_OP_CMP) chk("base order", {e.base, e.mem_first}, {dec_out.base, dec_out.mem_first});
		if (e.mode === cad_pkg::CAD_AM_REGIDX) chk("index", e.index, dec_out.index);
		if (e.op === cad_pkg::CAD_OP_AND) chk("imm", e.imm, dec_out.imm);
		if (e.mode === cad_pkg::CAD_AM_REG) chk("dest_reg", e.dest_reg, dec_out.dest_reg);
		if (e.mode inside {[4'h4:4'h5], [4'h9:4'hb]}) chk("offset", e.offset, dec_out.offset);
	endtask
	task automatic t_cmp_idx();
		run({8'h17, 8'h3f}, 0, mk(2'h1, 4'h6, 4'h1, 4'h2, 1'h0, 24'h0, 8'h0, 3'h2, 4'h0));
		run({8'h17, 8'h4f}, 0, mk(2'h1, 4'h6, 4'h3, 4'h4, 1'h0, 24'h0, 8'h0, 3'h2, 4'h0));
		run({8'h17, 8'h8f}, 0, mk(2'h1, 4'h6, 4'h2, 4'h1, 1'h1, 24'h0, 8'h0, 3'h2, 4'h0));
		run({8'h17, 8'hff}, 0, mk(2'h1, 4'h6, 4'h1, 4'h3, 1'h1, 24'h0, 8'h0, 3'h2, 4'h0));
	endtask
	task automatic t_cmp_ptr();
		run({8'h16, 8'haf}, 0, mk(2'h1, 4'h3, 4'h2, 4'h0, 1'h1, 24'h0, 8'h0, 3'h2, 4'h0));
		run({8'h16, 8'h9f}, 0, mk(2'h1, 4'h2, 4'h1, 4'h0, 1'h1, 24'h0, 8'h0, 3'h2, 4'h0));
		run({8'h16, 8'hff}, 0, mk(2'h1, 4'h1, 4'h4, 4'h0, 1'h1, 24'h0, 8'h0, 3'h2, 4'h0));
	endtask
	task automatic t_cmp_ofs();
		run({8'h06, 8'h9f, 8'h80}, 1, mk(2'h1, 4'h4, 4'h5, 4'h0, 1'h1, 24'h80, 8'h0, 3'h3, 4'h0));
		run({8'h06, 8'h1f, 8'h44}, 0, mk(2'h1, 4'h4, 4'h5, 4'h0, 1'h0, 24'h44, 8'h0, 3'h3, 4'h0));
		run({8'h0a, 8'haf, 8'h11, 8'h22, 8'h33}, 0, mk(2'h1, 4'h5, 4'h8, 4'h0, 1'h1, 24'h332211, 8'h0, 3'h5, 4'h0));
	endtask
	task automatic t_and();
		run({8'hac, 8'h55}, 0, mk(2'h2, 4'h7, 4'h0, 4'h0, 1'h0, 24'h0, 8'h55, 3'h2, 4'h0));
		run({8'h7c, 8'h53, 8'ha5}, 0, mk(2'h2, 4'h8, 4'h0, 4'h0, 1'h0, 24'h0, 8'ha5, 3'h3, 4'h5));
		run({8'h6c, 8'h12, 8'h34}, 0, mk(2'h2, 4'h9, 4'h0, 4'h0, 1'h0, 24'h12, 8'h34, 3'h3, 4'h0));
		run({8'h3c, 8'h6c, 8'h9a, 8'hbc}, 0, mk(2'h2, 4'ha, 4'h0, 4'h0, 1'h0, 24'h9a, 8'hbc, 3'h4, 4'h0));
		run({8'h01, 8'h6c, 8'hee, 8'h0f}, 0, mk(2'h2, 4'hb, 4'h0, 4'h0, 1'h0, 24'hee, 8'h0f, 3'h4, 4'h0));
	endtask
	task automatic t_bad();
		run({8'h17, 8'h2f}, 0, '0);
		run({8'h3c, 8'h11}, 0, '0);
		run({8'h16, 8'h8e}, 0, '0);
		run({8'hff}, 0, '0);
	endtask
	task automatic results();
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge core_clk_in);
		resetn_in = 1'b1;
		t_cmp_idx();
		t_bad();
		t_cmp_ptr();
		t_cmp_ofs();
		t_and();
		results();
	end
endmodule
`default_nettype wire
